/* logic/sipo_driver_pkg.sv */
/*
 * package for the serial-in parallel-out sink driver: widths, reset values,
 * synchroniser depth and packed carriers for pin groups.
 * assumes nothing beyond a systemverilog compiler.
 */
package sipo_driver_pkg;
  localparam int         STAGES_W      = 8;
  localparam int         SYNC_DEPTH    = 2;
  localparam logic [7:0] SHIFT_RST     = 8'h00;
  localparam logic [7:0] STORE_RST     = 8'h00;
  localparam logic       CASCADE_RST   = 1'b0;
  localparam logic [2:0] PIN_IDLE      = 3'h0;

  // raw control pins as sampled from outside the core clock domain
  typedef struct packed {
    logic shift_clock_in;
    logic latch_clock;
    logic serial_data_in;
  } pins_type;

  // sink gate drive, one bit per open-drain output plus its enable
  typedef struct packed {
    logic [7:0] sink_on;
    logic [7:0] sink_oe;
  } sink_type;
endpackage

/* logic/pin_sync.sv */
/*
 * two-stage synchroniser for a bundle of asynchronous pin levels.
 * assumes inputs are levels slow against core_clk; first stage read only by
 * the second.
 */
`timescale 1ns/1ps
module pin_sync #(
  parameter int          WIDTH    = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // meta_ff feeds sync_out only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_ff  <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

/* logic/sipo_driver.sv */
/*
 * serial-in parallel-out shift register, storage latch and open-drain sink
 * driver, all run on core_clk with pin clocks edge-detected after syncing.
 * assumes the pin clocks are much slower than core_clk (several core cycles
 * per high and low phase) and that the pad resolves the open-drain wire.
 */
// Contract
// - shift on shift clock rise, capture serial
// - latch clock rise copies shift into storage
// - clear high passes storage toward outputs
// - clear low zeroes shift, storage, cascade and sink registers
// - enable high forces all sinks off
// - enable low outputs follow storage
// - buffer bit high means sink on
// - cascade output updates on shift falling edge
`timescale 1ns/1ps
module sipo_driver #(
  parameter int STAGES = sipo_driver_pkg::STAGES_W
) (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   shift_clock_in,
  input  wire logic                   latch_clock,
  input  wire logic                   serial_data_in,
  input  wire logic                   clear_n,
  input  wire logic                   out_enable_n,
  output logic                        cascade_serial_out,
  output sipo_driver_pkg::sink_type   sink_ff
);
  // the shift, storage and sink paths are written for exactly eight bits
  if (STAGES != sipo_driver_pkg::STAGES_W) begin : g_bad_stages
    $error("sipo_driver supports only eight stages");
  end

  sipo_driver_pkg::pins_type raw_pins;
  sipo_driver_pkg::pins_type sync_pins;
  logic [1:0]       ctl_sync;
  logic             clear_n_s;
  logic             oe_n_s;
  logic             shift_prev_ff;
  logic             latch_prev_ff;
  logic [7:0]       shift_ff;
  logic [7:0]       store_ff;
  logic [7:0]       nxt_shift;
  logic [7:0]       nxt_store;
  logic             nxt_cascade;
  logic [7:0]       nxt_sink;
  wire              shift_rise;
  wire              shift_fall;
  wire              latch_rise;
  wire  [7:0]       passed;

  assign raw_pins = '{shift_clock_in: shift_clock_in, latch_clock: latch_clock,
                      serial_data_in: serial_data_in};

  // every pin passes two flops; clear and enable idle inactive (high)
  pin_sync #(.WIDTH(3), .RST_VAL(sipo_driver_pkg::PIN_IDLE)) u_sync_data (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (raw_pins),
    .sync_out (sync_pins)
  );
  pin_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_sync_ctl (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({clear_n, out_enable_n}),
    .sync_out (ctl_sync)
  );
  assign clear_n_s = ctl_sync[1];
  assign oe_n_s    = ctl_sync[0];

  // edge detection on the synchronised pin clocks
  assign shift_rise = sync_pins.shift_clock_in & ~shift_prev_ff;
  assign shift_fall = ~sync_pins.shift_clock_in & shift_prev_ff;
  assign latch_rise = sync_pins.latch_clock & ~latch_prev_ff;

  // clear dominates any clock edge in the same cycle
  assign nxt_shift = !clear_n_s ? sipo_driver_pkg::SHIFT_RST :
                     shift_rise ? {shift_ff[6:0], sync_pins.serial_data_in} :
                     shift_ff;
  assign nxt_store = !clear_n_s ? sipo_driver_pkg::STORE_RST :
                     latch_rise ? shift_ff : store_ff;
  // latch takes the pre-shift value if both clocks rise together, like the pin part
  assign nxt_cascade = !clear_n_s ? sipo_driver_pkg::CASCADE_RST :
                       shift_fall ? shift_ff[7] : cascade_serial_out;

  // storage reaches the buffer only while clear is released
  assign passed   = clear_n_s ? store_ff : 8'h00;
  // the buffer follows storage without waiting for any pin clock edge
  assign nxt_sink = oe_n_s ? 8'h00 : passed;

  // edge history flops
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_prev_ff <= 1'b0;
      latch_prev_ff <= 1'b0;
    end else begin
      shift_prev_ff <= sync_pins.shift_clock_in;
      latch_prev_ff <= sync_pins.latch_clock;
    end
  end

  // shift and storage registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_ff <= sipo_driver_pkg::SHIFT_RST;
      store_ff <= sipo_driver_pkg::STORE_RST;
    end else begin
      shift_ff <= nxt_shift;
      store_ff <= nxt_store;
    end
  end

  // registered outputs; sink drives the gate low to release the drain
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cascade_serial_out <= sipo_driver_pkg::CASCADE_RST;
      sink_ff            <= '0;
    end else begin
      cascade_serial_out <= nxt_cascade;
      sink_ff.sink_on    <= nxt_sink;
      sink_ff.sink_oe    <= nxt_sink;
    end
  end
endmodule

/* tb/sipo_driver_assertions.sv */
/* port checker for sipo_driver.
   assumes clear and enable levels held over 4 core cycles */
`timescale 1ns/1ps
module sipo_driver_assertions #(parameter int STAGES = 8) (
  input logic                      core_clk,
  input logic                      sys_rst,
  input logic                      shift_clock_in,
  input logic                      latch_clock,
  input logic                      serial_data_in,
  input logic                      clear_n,
  input logic                      out_enable_n,
  input logic                      cascade_serial_out,
  input sipo_driver_pkg::sink_type sink_ff
);
  // margins cover the two sync stages plus the output flop
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_oe_off; out_enable_n [*5] |-> sink_ff.sink_on == 8'h00; endproperty
  a_oe_off: assert property (p_oe_off) else $error("sinks on while disabled");
  property p_oe_fast; $rose(out_enable_n) |-> ##[1:4] sink_ff.sink_on == 8'h00; endproperty
  a_oe_fast: assert property (p_oe_fast) else $error("slow disable");
  property p_clr; !clear_n [*5] |-> sink_ff == '0 && !cascade_serial_out; endproperty
  a_clr: assert property (p_clr) else $error("not cleared");
  property p_clr_fast; $fell(clear_n) |-> ##[1:4] !cascade_serial_out; endproperty
  a_clr_fast: assert property (p_clr_fast) else $error("slow clear");
  property p_pair; sink_ff.sink_on == sink_ff.sink_oe; endproperty
  a_pair: assert property (p_pair) else $error("drive and enable differ");
  property p_cas_fall; $changed(cascade_serial_out) |-> !$past(shift_clock_in, 3) || !$past(clear_n, 3); endproperty
  a_cas_fall: assert property (p_cas_fall) else $error("cascade moved off falling edge");
  property p_hold; (!latch_clock && $stable(out_enable_n) && $stable(clear_n)) [*6] |-> $stable(sink_ff); endproperty
  a_hold: assert property (p_hold) else $error("sinks moved without latch");
  property p_en_only; sink_ff.sink_on != 8'h00 |-> !$past(out_enable_n, 3) || !$past(out_enable_n, 5); endproperty
  a_en_only: assert property (p_en_only) else $error("sinks on without enable");
  c_byte: cover property (sink_ff.sink_on == 8'ha5);
  c_cas: cover property ($rose(cascade_serial_out));
  c_clr: cover property ($fell(clear_n));
endmodule

/* tb/ctrl_model.sv */
/* controller model: shifts a byte msb first, then pulses the latch clock.
   assumes 4 core cycles per phase are enough for the pin synchroniser */
`timescale 1ns/1ps
module ctrl_model (
  input  logic core_clk,
  output logic shift_clock_in,
  output logic latch_clock,
  output logic serial_data_in
);
  // pin clocks stand low between frames
  initial {shift_clock_in, latch_clock, serial_data_in} = 3'h0;
  task automatic phase(input logic s, input logic l);
    shift_clock_in <= s;
    latch_clock <= l;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic latch();
    phase(1'b0, 1'b1);
    phase(1'b0, 1'b0);
    serial_data_in <= ~serial_data_in; // released data shows inverse
  endtask
  // data set in the low phase so it is settled before the rise
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serial_data_in <= b[i];
      phase(1'b0, 1'b0);
      phase(1'b1, 1'b0);
    end
    latch();
  endtask
endmodule

/* tb/tb_sipo_driver.sv */
/* bench for sipo_driver: byte rows, then enable and clear cases.
   assumes ctrl_model drives the two pin clocks and data */
`timescale 1ns/1ps
module tb_sipo_driver;
  logic core_clk = 1'b0, sys_rst = 1'b1, clear_n = 1'b1, out_enable_n = 1'b0;
  logic shift_clock_in, latch_clock, serial_data_in, cascade_serial_out;
  sipo_driver_pkg::sink_type sink_ff;
  int fails = 0, checked = 0;
  logic [8:0] rows [4] = '{9'h0a5, 9'h03c, 9'h081, 9'h1ff}; // bit 8 is the disable
  always #5 core_clk = ~core_clk;
  sipo_driver i_sipo_driver (.core_clk, .sys_rst, .shift_clock_in, .latch_clock, .serial_data_in,
    .clear_n, .out_enable_n, .cascade_serial_out, .sink_ff);
  ctrl_model i_ctrl_model (.core_clk, .shift_clock_in, .latch_clock, .serial_data_in);
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // waits of 6 cycles exceed the 4 cycle output latency
  initial begin
    repeat (16) @(posedge core_clk);
    chk("reset_sink", 8'h00, sink_ff.sink_on | sink_ff.sink_oe);
    chk("reset_cascade", 8'h00, {7'h00, cascade_serial_out});
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("idle_sink", 8'h00, sink_ff.sink_on);
    foreach (rows[i]) begin
      out_enable_n <= rows[i][8];
      i_ctrl_model.send(rows[i][7:0]);
      repeat (6) @(posedge core_clk);
      chk("sink", rows[i][8] ? 8'h00 : rows[i][7:0], sink_ff.sink_on);
      chk("cascade", {7'h00, rows[i][7]}, {7'h00, cascade_serial_out});
    end
    out_enable_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk("enable", 8'hff, sink_ff.sink_on);
    clear_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk("clear", 8'h00, sink_ff.sink_on | {7'h00, cascade_serial_out});
    clear_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    i_ctrl_model.latch();
    repeat (6) @(posedge core_clk);
    chk("cleared_shift", 8'h00, sink_ff.sink_on);
    report_and_stop();
  end
endmodule
bind sipo_driver sipo_driver_assertions #(.STAGES(STAGES)) i_sipo_driver_assertions (.core_clk, .sys_rst,
  .shift_clock_in, .latch_clock, .serial_data_in, .clear_n, .out_enable_n, .cascade_serial_out, .sink_ff);
